// file: logic/usb_ep_pkg.sv
package usb_ep_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register word addresses on the plain register port
  localparam logic [ADDR_W-1:0] EPR_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h4;

  // Endpoint control and status field positions
  localparam int RXDONE_BIT = 15;
  localparam int STAT_RX_LSB = 12;
  localparam int SETUP_BIT = 11;
  localparam int TYPE_LSB = 9;
  localparam int KIND_BIT = 8;
  localparam int TXDONE_BIT = 7;
  localparam int TRANSMIT_PID_TOGGLE_BIT = 6;
  localparam int STAT_TX_LSB = 4;
  localparam int EPNUM_LSB = 0;

  // Peripheral control register field positions
  localparam int CTRL_MASK_BIT = 0;
  localparam int CTRL_FRES_BIT = 1;

  localparam logic [DATA_W-1:0] EPR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    STAT_DISABLED = 2'h0,
    STAT_STALL = 2'h1,
    STAT_NAK = 2'h2,
    STAT_VALID = 2'h3
  } ep_stat_t;

  typedef enum logic [1:0] {
    XFER_BULK = 2'h0,
    XFER_CONTROL = 2'h1,
    XFER_ISO = 2'h2,
    XFER_INTERRUPT = 2'h3
  } xfer_kind_t;

  typedef enum logic [2:0] {EV_OUT, EV_SETUP, EV_IN, EV_IN_ACK, EV_IN_SENT} event_kind_t;

  typedef enum logic [2:0] {RESP_NONE, RESP_ACK, RESP_NAK, RESP_STALL, RESP_DATA} resp_t;

  typedef struct packed {
    logic valid;
    event_kind_t kind;
    logic [3:0] ep_num;
    logic data_good;
    logic data_nonempty;
  } link_event_t;

  typedef struct packed {
    logic valid;
    resp_t resp;
    logic data_pid;
  } reply_t;

endpackage

// file: logic/ep_handshake.sv
module ep_handshake (
  input wire usb_ep_pkg::event_kind_t kind,
  input wire usb_ep_pkg::xfer_kind_t xfer,
  input wire usb_ep_pkg::ep_stat_t stat_rx,
  input wire usb_ep_pkg::ep_stat_t stat_tx,
  input wire logic status_out,
  input wire logic data_good,
  input wire logic data_nonempty,
  output usb_ep_pkg::resp_t resp,
  output logic rx_accept
);

  always_comb
  begin
    resp = usb_ep_pkg::RESP_NONE;
    rx_accept = 1'b0;
    case (kind)
      usb_ep_pkg::EV_SETUP:
      begin
        // SETUP is never refused by NAK or STALL; NAK means silence
        if (xfer == usb_ep_pkg::XFER_CONTROL && data_good)
        begin
          if (stat_rx == usb_ep_pkg::STAT_STALL || stat_rx == usb_ep_pkg::STAT_VALID)
          begin
            resp = usb_ep_pkg::RESP_ACK;
            rx_accept = 1'b1;
          end
        end
      end
      usb_ep_pkg::EV_OUT:
      begin
        case (stat_rx)
          usb_ep_pkg::STAT_STALL: resp = usb_ep_pkg::RESP_STALL;
          usb_ep_pkg::STAT_NAK: resp = usb_ep_pkg::RESP_NAK;
          usb_ep_pkg::STAT_VALID:
          begin
            if (!data_good)
              resp = usb_ep_pkg::RESP_NONE;
            else if (xfer == usb_ep_pkg::XFER_ISO)
              rx_accept = 1'b1;
            else if (xfer == usb_ep_pkg::XFER_CONTROL && status_out && data_nonempty)
              resp = usb_ep_pkg::RESP_STALL;
            else
            begin
              resp = usb_ep_pkg::RESP_ACK;
              rx_accept = 1'b1;
            end
          end
          default: resp = usb_ep_pkg::RESP_NONE;
        endcase
      end
      usb_ep_pkg::EV_IN:
      begin
        case (stat_tx)
          usb_ep_pkg::STAT_STALL: resp = usb_ep_pkg::RESP_STALL;
          usb_ep_pkg::STAT_NAK: resp = usb_ep_pkg::RESP_NAK;
          usb_ep_pkg::STAT_VALID: resp = usb_ep_pkg::RESP_DATA;
          default: resp = usb_ep_pkg::RESP_NONE;
        endcase
      end
      default:
      begin
        resp = usb_ep_pkg::RESP_NONE;
        rx_accept = 1'b0;
      end
    endcase
  end

endmodule

// file: logic/usb_ep_ctrl.sv
// What this block does
// - Software write of one toggles a receive status bit; zero leaves it.
// - Good OUT or SETUP on non-iso endpoint forces receive status to NAK.
// - Iso endpoints: hardware never changes either status field after transactions.
// - Setup indicator shows last completed control transaction was SETUP; read-only.
// - Setup indicator frozen while receive done flag is set.
// - Type field: 00 bulk, 01 control, 10 iso, 11 interrupt.
// - Only control endpoints process SETUP; others ignore it.
// - Control endpoint with receive NAK gives no handshake to SETUP.
// - Control endpoint with receive STALL still accepts SETUP and flags it.
// - Kind bit: double buffer for bulk, status-out for control, else unused.
// - Status-out set: OUT with data gets STALL; clear: any OUT accepted.
// - Transmit done flag set on good IN; write zero clears, one keeps.
// - Transmit done raises endpoint interrupt; generic interrupt when mask set.
// - NAK, STALL or failed transactions never set transmit done.
// - Transmit toggle is next PID, inverted on host ACK, non-iso.
// - SETUP on control endpoint sets transmit toggle to one.
// - Iso sends DATA0; toggle inverts right after each sent packet.
// - Software write of one inverts transmit toggle; zero leaves it.
// - Transmit status toggled by software; good non-iso IN forces NAK.
// - Status codes: disabled silent, stall, nak, valid per direction.
// - Endpoint number matches incoming token endpoint numbers.
// - Receive done flag set when OUT or SETUP completes successfully.
// - Bus or forced reset clears fields but keeps both done flags.
//
// Our own choices: the placing of the registers and the plain strobed port.
module usb_ep_ctrl (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [usb_ep_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [usb_ep_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [usb_ep_pkg::DATA_W-1:0] reg_rdata,
  input wire logic bus_reset,
  input wire usb_ep_pkg::link_event_t link_event,
  output usb_ep_pkg::reply_t reply,
  output logic double_buffer_enable,
  output logic endpoint_irq,
  output logic generic_irq
);

  logic [1:0] rst_sync_reg;
  logic rst_n;

  logic receive_done_flag_reg;
  usb_ep_pkg::ep_stat_t stat_rx_reg;
  logic setup_seen_reg;
  usb_ep_pkg::xfer_kind_t endpoint_transfer_kind_reg;
  logic endpoint_type_modifier_reg;
  logic transmit_done_flag_reg;
  logic transmit_pid_toggle_reg;
  usb_ep_pkg::ep_stat_t stat_tx_reg;
  logic [3:0] endpoint_number_reg;
  logic transfer_done_irq_mask_reg;
  logic force_reset_reg;
  logic in_pending_reg;

  logic ep_write;
  logic ctrl_write;
  logic ep_hit;
  logic is_iso;
  logic is_ctrl;
  logic field_reset;
  usb_ep_pkg::resp_t resp;
  logic rx_accept;
  logic rx_done_set;
  logic setup_done;
  logic tx_done_set;
  logic [usb_ep_pkg::DATA_W-1:0] ep_word;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  assign ep_write = reg_write && reg_addr == usb_ep_pkg::EPR_ADDR;
  assign ctrl_write = reg_write && reg_addr == usb_ep_pkg::CTRL_ADDR;
  assign ep_hit = link_event.valid && link_event.ep_num == endpoint_number_reg;
  assign is_iso = endpoint_transfer_kind_reg == usb_ep_pkg::XFER_ISO;
  assign is_ctrl = endpoint_transfer_kind_reg == usb_ep_pkg::XFER_CONTROL;
  assign field_reset = bus_reset || force_reset_reg;

  ep_handshake handshake (
    .kind(link_event.kind),
    .xfer(endpoint_transfer_kind_reg),
    .stat_rx(stat_rx_reg),
    .stat_tx(stat_tx_reg),
    .status_out(endpoint_type_modifier_reg && is_ctrl),
    .data_good(link_event.data_good),
    .data_nonempty(link_event.data_nonempty),
    .resp(resp),
    .rx_accept(rx_accept)
  );

  // Completion events; an IN completes on host ACK, or on send for iso
  assign rx_done_set = ep_hit && rx_accept;
  assign setup_done = rx_done_set && link_event.kind == usb_ep_pkg::EV_SETUP;
  assign tx_done_set = in_pending_reg && link_event.valid && (
    (!is_iso && link_event.kind == usb_ep_pkg::EV_IN_ACK) ||
    (is_iso && link_event.kind == usb_ep_pkg::EV_IN_SENT));

  // Only a data answer arms the IN completion; NAK and STALL never do
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      in_pending_reg <= 1'b0;
    else if (ep_hit && link_event.kind == usb_ep_pkg::EV_IN)
      in_pending_reg <= resp == usb_ep_pkg::RESP_DATA;
    // Any other token before the handshake cancels the pending IN
    else if (field_reset || link_event.valid)
      in_pending_reg <= 1'b0;
  end

  // Done flags: set wins over a software clear, reset leaves them alone
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      receive_done_flag_reg <= 1'b0;
      transmit_done_flag_reg <= 1'b0;
    end
    else
    begin
      if (rx_done_set)
        receive_done_flag_reg <= 1'b1;
      else if (ep_write && !reg_wdata[usb_ep_pkg::RXDONE_BIT])
        receive_done_flag_reg <= 1'b0;
      if (tx_done_set)
        transmit_done_flag_reg <= 1'b1;
      else if (ep_write && !reg_wdata[usb_ep_pkg::TXDONE_BIT])
        transmit_done_flag_reg <= 1'b0;
    end
  end

  // Hardware forcing first, then the software toggle mask on top
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_rx_reg <= usb_ep_pkg::STAT_DISABLED;
      stat_tx_reg <= usb_ep_pkg::STAT_DISABLED;
    end
    else if (field_reset)
    begin
      stat_rx_reg <= usb_ep_pkg::STAT_DISABLED;
      stat_tx_reg <= usb_ep_pkg::STAT_DISABLED;
    end
    else
    begin
      stat_rx_reg <= usb_ep_pkg::ep_stat_t'(
        ((rx_done_set && !is_iso) ? usb_ep_pkg::STAT_NAK : stat_rx_reg) ^
        (ep_write ? reg_wdata[usb_ep_pkg::STAT_RX_LSB+:2] : 2'h0));
      stat_tx_reg <= usb_ep_pkg::ep_stat_t'(
        ((tx_done_set && !is_iso) ? usb_ep_pkg::STAT_NAK : stat_tx_reg) ^
        (ep_write ? reg_wdata[usb_ep_pkg::STAT_TX_LSB+:2] : 2'h0));
    end
  end

  // SETUP forces one; a host ACK or an iso send inverts
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      transmit_pid_toggle_reg <= 1'b0;
    else if (field_reset)
      transmit_pid_toggle_reg <= 1'b0;
    else if (setup_done)
      transmit_pid_toggle_reg <= 1'b1 ^ (ep_write && reg_wdata[usb_ep_pkg::TRANSMIT_PID_TOGGLE_BIT]);
    else
      transmit_pid_toggle_reg <= (transmit_pid_toggle_reg ^ tx_done_set) ^
        (ep_write && reg_wdata[usb_ep_pkg::TRANSMIT_PID_TOGGLE_BIT]);
  end

  // Read-only; updates only on control endpoints with the receive flag clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      setup_seen_reg <= 1'b0;
    else if (field_reset)
      setup_seen_reg <= 1'b0;
    else if (is_ctrl && !receive_done_flag_reg && (rx_done_set || tx_done_set))
      setup_seen_reg <= setup_done;
  end

  // Plain loaded fields
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      endpoint_transfer_kind_reg <= usb_ep_pkg::XFER_BULK;
      endpoint_type_modifier_reg <= 1'b0;
      endpoint_number_reg <= 4'h0;
    end
    else if (field_reset)
    begin
      endpoint_transfer_kind_reg <= usb_ep_pkg::XFER_BULK;
      endpoint_type_modifier_reg <= 1'b0;
      endpoint_number_reg <= 4'h0;
    end
    else if (ep_write)
    begin
      endpoint_transfer_kind_reg <= usb_ep_pkg::xfer_kind_t'(reg_wdata[usb_ep_pkg::TYPE_LSB+:2]);
      endpoint_type_modifier_reg <= reg_wdata[usb_ep_pkg::KIND_BIT];
      endpoint_number_reg <= reg_wdata[usb_ep_pkg::EPNUM_LSB+:4];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      transfer_done_irq_mask_reg <= usb_ep_pkg::CTRL_RESET[usb_ep_pkg::CTRL_MASK_BIT];
      force_reset_reg <= usb_ep_pkg::CTRL_RESET[usb_ep_pkg::CTRL_FRES_BIT];
    end
    else if (ctrl_write)
    begin
      transfer_done_irq_mask_reg <= reg_wdata[usb_ep_pkg::CTRL_MASK_BIT];
      force_reset_reg <= reg_wdata[usb_ep_pkg::CTRL_FRES_BIT];
    end
  end

  always_comb
  begin
    ep_word = usb_ep_pkg::READ_ZERO;
    ep_word[usb_ep_pkg::RXDONE_BIT] = receive_done_flag_reg;
    ep_word[usb_ep_pkg::STAT_RX_LSB+:2] = stat_rx_reg;
    ep_word[usb_ep_pkg::SETUP_BIT] = setup_seen_reg;
    ep_word[usb_ep_pkg::TYPE_LSB+:2] = endpoint_transfer_kind_reg;
    ep_word[usb_ep_pkg::KIND_BIT] = endpoint_type_modifier_reg;
    ep_word[usb_ep_pkg::TXDONE_BIT] = transmit_done_flag_reg;
    ep_word[usb_ep_pkg::TRANSMIT_PID_TOGGLE_BIT] = transmit_pid_toggle_reg;
    ep_word[usb_ep_pkg::STAT_TX_LSB+:2] = stat_tx_reg;
    ep_word[usb_ep_pkg::EPNUM_LSB+:4] = endpoint_number_reg;
  end

  // Read data stands for the one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= usb_ep_pkg::READ_ZERO;
    else if (reg_read && reg_addr == usb_ep_pkg::EPR_ADDR)
      reg_rdata <= ep_word;
    else if (reg_read && reg_addr == usb_ep_pkg::CTRL_ADDR)
    begin
      reg_rdata <= usb_ep_pkg::READ_ZERO;
      reg_rdata[usb_ep_pkg::CTRL_MASK_BIT] <= transfer_done_irq_mask_reg;
      reg_rdata[usb_ep_pkg::CTRL_FRES_BIT] <= force_reset_reg;
    end
    else
      reg_rdata <= usb_ep_pkg::READ_ZERO;
  end

  // Handshake answer one cycle after the token; iso data always DATA0
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reply <= '0;
    else
    begin
      reply.valid <= ep_hit && resp != usb_ep_pkg::RESP_NONE;
      reply.resp <= ep_hit ? resp : usb_ep_pkg::RESP_NONE;
      reply.data_pid <= transmit_pid_toggle_reg && !is_iso;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      endpoint_irq <= 1'b0;
      generic_irq <= 1'b0;
      double_buffer_enable <= 1'b0;
    end
    else
    begin
      endpoint_irq <= receive_done_flag_reg || transmit_done_flag_reg;
      generic_irq <= transfer_done_irq_mask_reg &&
        (receive_done_flag_reg || transmit_done_flag_reg);
      double_buffer_enable <= endpoint_type_modifier_reg &&
        endpoint_transfer_kind_reg == usb_ep_pkg::XFER_BULK;
    end
  end

  rx_toggle_a: assert property (@(posedge clock) disable iff (!rst_n)
    ep_write && !field_reset && !rx_done_set |=>
    stat_rx_reg == ($past(stat_rx_reg) ^ $past(reg_wdata[usb_ep_pkg::STAT_RX_LSB+:2])))
    else $error("receive status not toggled by write");

  rx_nak_a: assert property (@(posedge clock) disable iff (!rst_n)
    rx_done_set && !is_iso && !ep_write && !field_reset |=> stat_rx_reg == usb_ep_pkg::STAT_NAK)
    else $error("receive status not forced to NAK");

  iso_status_a: assert property (@(posedge clock) disable iff (!rst_n)
    is_iso && !ep_write && !field_reset |=> $stable(stat_rx_reg) && $stable(stat_tx_reg))
    else $error("iso status changed by hardware");

  setup_freeze_a: assert property (@(posedge clock) disable iff (!rst_n)
    receive_done_flag_reg && !field_reset |=> $stable(setup_seen_reg))
    else $error("setup indicator changed while frozen");

  setup_ignore_a: assert property (@(posedge clock) disable iff (!rst_n)
    ep_hit && link_event.kind == usb_ep_pkg::EV_SETUP && !is_ctrl |=> !reply.valid)
    else $error("non-control endpoint answered SETUP");

  setup_nak_a: assert property (@(posedge clock) disable iff (!rst_n)
    ep_hit && link_event.kind == usb_ep_pkg::EV_SETUP && stat_rx_reg == usb_ep_pkg::STAT_NAK
    |=> !reply.valid && !$rose(receive_done_flag_reg))
    else $error("SETUP answered under NAK");

  status_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    ep_hit && link_event.kind == usb_ep_pkg::EV_OUT && is_ctrl && endpoint_type_modifier_reg &&
    stat_rx_reg == usb_ep_pkg::STAT_VALID && link_event.data_good && link_event.data_nonempty
    |=> reply.valid && reply.resp == usb_ep_pkg::RESP_STALL)
    else $error("status-out OUT with data not stalled");

  tx_done_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    transmit_done_flag_reg |=> endpoint_irq && (generic_irq == $past(transfer_done_irq_mask_reg)))
    else $error("transmit done interrupt missing");

  tx_ack_toggle_a: assert property (@(posedge clock) disable iff (!rst_n)
    tx_done_set && !is_iso && !ep_write && !field_reset && !setup_done
    |=> transmit_pid_toggle_reg != $past(transmit_pid_toggle_reg) && transmit_done_flag_reg)
    else $error("toggle not inverted on host ACK");

  setup_toggle_a: assert property (@(posedge clock) disable iff (!rst_n)
    setup_done && !ep_write && !field_reset |=> transmit_pid_toggle_reg)
    else $error("SETUP did not set transmit toggle");

  flag_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    field_reset && !ep_write |=>
    !$fell(receive_done_flag_reg) && !$fell(transmit_done_flag_reg))
    else $error("reset cleared a done flag");

  tx_nak_a: assert property (@(posedge clock) disable iff (!rst_n)
    tx_done_set && !is_iso && !ep_write && !field_reset |=> stat_tx_reg == usb_ep_pkg::STAT_NAK)
    else $error("transmit status not forced to NAK");

  tx_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    ep_write && !reg_wdata[usb_ep_pkg::TXDONE_BIT] && !tx_done_set |=> !transmit_done_flag_reg)
    else $error("transmit done flag not cleared by write of zero");

  silent_disabled_a: assert property (@(posedge clock) disable iff (!rst_n)
    ep_hit && link_event.kind == usb_ep_pkg::EV_OUT && stat_rx_reg == usb_ep_pkg::STAT_DISABLED
    |=> !reply.valid)
    else $error("disabled endpoint answered OUT");

endmodule

// file: dv/usb_host_model.sv
module usb_host_model (
  input wire logic clock,
  output usb_ep_pkg::link_event_t link_event,
  input wire usb_ep_pkg::reply_t reply
);
  timeunit 1ns;
  timeprecision 100ps;

  initial link_event = '0;

  // One token per call; the answer is sampled in the cycle after the token is taken
  task automatic send(input usb_ep_pkg::event_kind_t kind, input logic [3:0] ep,
                      input logic good, input logic nonempty,
                      output usb_ep_pkg::reply_t r);
    usb_ep_pkg::link_event_t ev;
    ev = '{valid: 1'b1, kind: kind, ep_num: ep, data_good: good, data_nonempty: nonempty};
    @(posedge clock);
    link_event <= ev;
    @(posedge clock);
    // Released fields carry the inverse, so a stale token never passes by luck
    link_event <= {1'b0, ~ev[$bits(ev)-2:0]};
    #1;
    r = reply;
  endtask

  // Data goes back with a handshake on normal endpoints, a bare end marker on iso
  task automatic in_xfer(input logic [3:0] ep, input logic iso, input int gap,
                         output usb_ep_pkg::reply_t r);
    usb_ep_pkg::reply_t ignored;
    send(usb_ep_pkg::EV_IN, ep, 1'b1, 1'b0, r);
    repeat (gap) @(posedge clock);
    if (r.valid === 1'b1 && r.resp === usb_ep_pkg::RESP_DATA)
      send(iso ? usb_ep_pkg::EV_IN_SENT : usb_ep_pkg::EV_IN_ACK, ep, 1'b1, 1'b0,
           ignored);
  endtask
endmodule

// file: dv/tb_top.sv
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [3:0] EPA = usb_ep_pkg::EPR_ADDR;
  localparam logic [3:0] CTA = usb_ep_pkg::CTRL_ADDR;
  logic clock = 1'b0;
  logic reset_n;
  logic bus_reset;
  logic reg_write;
  logic reg_read;
  logic [usb_ep_pkg::ADDR_W-1:0] reg_addr;
  logic [usb_ep_pkg::DATA_W-1:0] reg_wdata;
  logic [usb_ep_pkg::DATA_W-1:0] reg_rdata;
  usb_ep_pkg::link_event_t link_event;
  usb_ep_pkg::reply_t reply;
  usb_ep_pkg::reply_t r;
  logic double_buffer_enable;
  logic endpoint_irq;
  logic generic_irq;
  int n_fail = 0;
  int checked = 0;

  always #4 clock = ~clock;

  usb_ep_ctrl uut (
    .clock(clock),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .bus_reset(bus_reset),
    .link_event(link_event),
    .reply(reply),
    .double_buffer_enable(double_buffer_enable),
    .endpoint_irq(endpoint_irq),
    .generic_irq(generic_irq)
  );

  usb_host_model host (
    .clock(clock),
    .link_event(link_event),
    .reply(reply)
  );

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic expect_ep(input logic [15:0] exp);
    logic [15:0] d;
    rd(EPA, d);
    `CHK(d, exp)
  endtask

  // Toggle fields are steered by xor against the read value; done bits written as keep
  task automatic cfg(input logic [15:0] want);
    logic [15:0] c;
    rd(EPA, c);
    wr(EPA, {2'b10, c[13:12] ^ want[13:12], 1'b0, want[10:8], 1'b1, c[6] ^ want[6],
             c[5:4] ^ want[5:4], want[3:0]});
  endtask

  task automatic tok(input usb_ep_pkg::event_kind_t k, input logic [3:0] ep,
                     input logic good, input logic nonempty);
    host.send(k, ep, good, nonempty, r);
  endtask

  task automatic s_regs();
    logic [15:0] d;
    rd(EPA, d);
    `CHK(d, usb_ep_pkg::EPR_RESET)
    rd(CTA, d);
    `CHK(d, usb_ep_pkg::CTRL_RESET)
    wr(EPA, 16'hFFFF);
    expect_ep(16'h377F);
    wr(EPA, 16'h0000);
    expect_ep(16'h3070);
    wr(EPA, 16'h3070);
    expect_ep(16'h0000);
    wr(4'h8, 16'hFFFF);
    rd(4'h8, d);
    `CHK(d, usb_ep_pkg::READ_ZERO)
    expect_ep(16'h0000);
    $display("test regs done");
  endtask

  task automatic s_out();
    usb_ep_pkg::resp_t exp_r [4];
    exp_r = '{usb_ep_pkg::RESP_NONE, usb_ep_pkg::RESP_STALL, usb_ep_pkg::RESP_NAK,
              usb_ep_pkg::RESP_ACK};
    wr(CTA, 16'h0001);
    cfg(16'h3003);
    tok(usb_ep_pkg::EV_OUT, 4'h5, 1'b1, 1'b1);
    `CHK(r.valid, 1'b0)
    tok(usb_ep_pkg::EV_OUT, 4'h3, 1'b0, 1'b1);
    `CHK(r.valid, 1'b0)
    expect_ep(16'h3003);
    for (int i = 0; i < 4; i++)
    begin
      cfg({2'b00, 2'(i), 12'h003});
      tok(usb_ep_pkg::EV_OUT, 4'h3, 1'b1, 1'b1);
      `CHK(r.valid, 1'(i != 0))
      if (i != 0)
        `CHK(r.resp, exp_r[i])
    end
    expect_ep(16'hA003);
    `CHK(endpoint_irq, 1'b1)
    `CHK(generic_irq, 1'b1)
    $display("test out done");
  endtask

  task automatic s_in();
    wr(EPA, 16'h0003);
    cfg(16'h2033);
    tok(usb_ep_pkg::EV_IN, 4'h3, 1'b1, 1'b0);
    `CHK(r.resp, usb_ep_pkg::RESP_DATA)
    tok(usb_ep_pkg::EV_OUT, 4'h9, 1'b1, 1'b1);
    expect_ep(16'h2033);
    host.in_xfer(4'h3, 1'b0, 2, r);
    `CHK(r.data_pid, 1'b0)
    expect_ep(16'h20E3);
    `CHK(generic_irq, 1'b1)
    wr(EPA, 16'h8003);
    expect_ep(16'h2063);
    `CHK(endpoint_irq, 1'b0)
    host.in_xfer(4'h3, 1'b0, 0, r);
    `CHK(r.resp, usb_ep_pkg::RESP_NAK)
    expect_ep(16'h2063);
    wr(CTA, 16'h0000);
    cfg(16'h2073);
    host.in_xfer(4'h3, 1'b0, 0, r);
    `CHK(r.data_pid, 1'b1)
    expect_ep(16'h20A3);
    `CHK(endpoint_irq, 1'b1)
    `CHK(generic_irq, 1'b0)
    $display("test in done");
  endtask

  task automatic s_setup();
    wr(EPA, 16'h8003);
    cfg(16'h3003);
    tok(usb_ep_pkg::EV_SETUP, 4'h3, 1'b1, 1'b1);
    `CHK(r.valid, 1'b0)
    expect_ep(16'h3003);
    cfg(16'h1203);
    tok(usb_ep_pkg::EV_SETUP, 4'h3, 1'b1, 1'b1);
    `CHK(r.resp, usb_ep_pkg::RESP_ACK)
    expect_ep(16'hAA43);
    tok(usb_ep_pkg::EV_SETUP, 4'h3, 1'b1, 1'b1);
    `CHK(r.valid, 1'b0)
    cfg(16'h3243);
    tok(usb_ep_pkg::EV_OUT, 4'h3, 1'b1, 1'b1);
    expect_ep(16'hAA43);
    wr(EPA, 16'h0283);
    cfg(16'h3243);
    tok(usb_ep_pkg::EV_OUT, 4'h3, 1'b1, 1'b1);
    expect_ep(16'hA243);
    $display("test setup done");
  endtask

  task automatic s_kind();
    cfg(16'h3303);
    tok(usb_ep_pkg::EV_OUT, 4'h3, 1'b1, 1'b1);
    `CHK(r.resp, usb_ep_pkg::RESP_STALL)
    tok(usb_ep_pkg::EV_OUT, 4'h3, 1'b1, 1'b0);
    `CHK(r.resp, usb_ep_pkg::RESP_ACK)
    `CHK(double_buffer_enable, 1'b0)
    cfg(16'h0103);
    repeat (2) @(posedge clock);
    #1;
    `CHK(double_buffer_enable, 1'b1)
    $display("test kind done");
  endtask

  task automatic s_iso();
    wr(EPA, 16'h0003);
    // Iso endpoint only ever gets valid or disabled status from software
    cfg(16'h3433);
    host.in_xfer(4'h3, 1'b1, 0, r);
    `CHK(r.data_pid, 1'b0)
    tok(usb_ep_pkg::EV_OUT, 4'h3, 1'b1, 1'b1);
    `CHK(r.valid, 1'b0)
    expect_ep(16'hB4F3);
    host.in_xfer(4'h3, 1'b1, 1, r);
    `CHK(r.data_pid, 1'b0)
    expect_ep(16'hB4B3);
    $display("test iso done");
  endtask

  task automatic s_reset();
    @(posedge clock);
    bus_reset <= 1'b1;
    @(posedge clock);
    bus_reset <= 1'b0;
    expect_ep(16'h8080);
    wr(EPA, 16'h8285);
    wr(CTA, 16'h0002);
    wr(CTA, 16'h0000);
    expect_ep(16'h8080);
    $display("test reset done");
  endtask

  task automatic tally_and_finish();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    reset_n = 1'b0;
    bus_reset = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    s_regs();
    s_out();
    s_in();
    s_setup();
    s_kind();
    s_iso();
    s_reset();
    tally_and_finish();
  end

  // All tests need well under a thousand cycles
  initial
  begin
    #(8 * 4000);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
